// [rtl/keyfob_consts.vh]
// timing, frame and field constants for the keyfob wake and transmit controller
`ifndef KEYFOB_CONSTS_VH
`define KEYFOB_CONSTS_VH

`define CLK_MHZ 125
// bit time in ns at 1200 bit/s, rounded down
`define BIT_TIME_NS 833333
`define BIT_CYCLES ((`BIT_TIME_NS * `CLK_MHZ) / 1000)
// oscillator and pll settle time in us
`define PLL_SETTLE_US 2000
`define PLL_SETTLE_CYCLES (`PLL_SETTLE_US * `CLK_MHZ)
// scan pulse width in ns, kept short
`define SCAN_PULSE_NS 16
`define SCAN_PULSE_CYCLES ((`SCAN_PULSE_NS * `CLK_MHZ + 999) / 1000)

`define RUNIN_BITS 4
`define RUNIN_PATTERN 4'ha
`define SYNC_BYTE_0 8'h55
`define SYNC_BYTE_1 8'haa
// status and option bit positions
`define STATUS_WAKE_BIT 7
`define OPTION_WAKE_EN_BIT 7
`define PAYLOAD_HI 8'ha5

`endif

// [rtl/keyfob_ctrl.v]
// keyfob controller: sleep, key-change wake, 2x2 scan, frame transmit, transmitter power-down
// How it works
// - key input change during sleep wakes controller
// - pull-ups on while pullup_disable_n is low
// - wake flag set only by wake from sleep
// - wake armed only if pin_wake_enable_n cleared
// - after wake, find key, insert code, transmit
// - frame end drives power and data lines low
// - scan matrix at most two by two keys
// - scan pulses kept as short as possible
// - during pll settle, amplitude low; freq high in fsk mode, low otherwise
// - frame is run-in, 0x55, 0xaa, two payload bytes
// - each byte sent msb first
`timescale 1ns/100ps
`include "keyfob_consts.vh"
module keyfob_ctrl #(
    parameter BIT_CYCLES = `BIT_CYCLES,
    parameter PLL_CYCLES = `PLL_SETTLE_CYCLES,
    parameter FSK_MODE = 1'b1,
    parameter USE_POWER_LINE = 1'b1,
    parameter MATRIX_SCAN = 1'b1
) (
    input wire clk,
    input wire reset,
    input wire key_input_a,
    input wire key_input_b,
    input wire pullup_disable_n,
    input wire pin_wake_enable_n,
    output reg pullup_enable_ff,
    output reg scan_row_a_ff,
    output reg scan_row_b_ff,
    output reg scan_row_a_oe_ff,
    output reg scan_row_b_oe_ff,
    output reg tx_power_line_ff,
    output reg amplitude_data_line_ff,
    output reg frequency_data_line_ff,
    output reg asleep_ff,
    output reg pin_wake_flag_ff,
    output reg [7:0] key_code_ff
);
    localparam [6:0] ST_SLEEP = 7'h01;
    localparam [6:0] ST_WAKE = 7'h02;
    localparam [6:0] ST_SCAN = 7'h04;
    localparam [6:0] ST_SETTLE = 7'h08;
    localparam [6:0] ST_SEND = 7'h10;
    localparam [6:0] ST_END = 7'h20;
    localparam [6:0] ST_IDLE = 7'h40;
    localparam [5:0] FRAME_BITS = 6'd36;
    // integer first, then an explicit slice so the width cut is on purpose
    localparam integer SCAN_CYC_INT = `SCAN_PULSE_CYCLES;
    localparam [7:0] SCAN_CYC = SCAN_CYC_INT[7:0];

    wire key_a_sync;
    wire key_b_sync;
    reg [6:0] state_ff;
    reg [31:0] cnt_ff;
    reg [5:0] bit_ff;
    reg [35:0] shift_ff;
    reg key_a_last_ff;
    reg key_b_last_ff;
    reg armed_ff;
    reg [1:0] scan_step_ff;
    reg [3:0] keys_ff;
    reg [7:0] nxt_code;

    pin_sync #(.RESET_VAL(1'b1)) sync_a (
        .clk(clk),
        .reset(reset),
        .pin(key_input_a),
        .level_ff(key_a_sync)
    );
    pin_sync #(.RESET_VAL(1'b1)) sync_b (
        .clk(clk),
        .reset(reset),
        .pin(key_input_b),
        .level_ff(key_b_sync)
    );

    // code from pressed keys; lowest index wins, zero means none still held
    always @* begin
        nxt_code = 8'h00;
        if (keys_ff[0]) begin
            nxt_code = 8'h01;
        end else if (keys_ff[1]) begin
            nxt_code = 8'h02;
        end else if (keys_ff[2]) begin
            nxt_code = 8'h03;
        end else if (keys_ff[3]) begin
            nxt_code = 8'h04;
        end
    end

    // weak pull-ups follow the active-low control bit
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pullup_enable_ff <= 1'b0;
        end else begin
            pullup_enable_ff <= ~pullup_disable_n;
        end
    end

    // main sequencer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 32'h0000_0000;
            bit_ff <= 6'h00;
            shift_ff <= 36'h0_0000_0000;
            key_a_last_ff <= 1'b1;
            key_b_last_ff <= 1'b1;
            armed_ff <= 1'b0;
            scan_step_ff <= 2'h0;
            keys_ff <= 4'h0;
            scan_row_a_ff <= 1'b0;
            scan_row_b_ff <= 1'b0;
            scan_row_a_oe_ff <= 1'b0;
            scan_row_b_oe_ff <= 1'b0;
            tx_power_line_ff <= 1'b0;
            amplitude_data_line_ff <= 1'b0;
            frequency_data_line_ff <= 1'b0;
            asleep_ff <= 1'b0;
            pin_wake_flag_ff <= 1'b0; // other resets leave it clear
            key_code_ff <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // sleep entry; arming sampled here, like clearing the bit before sleep
                    armed_ff <= ~pin_wake_enable_n;
                    key_a_last_ff <= key_a_sync;
                    key_b_last_ff <= key_b_sync;
                    asleep_ff <= 1'b1;
                    state_ff <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (armed_ff && ((key_a_sync != key_a_last_ff) ||
                            (key_b_sync != key_b_last_ff))) begin
                        pin_wake_flag_ff <= 1'b1;
                        asleep_ff <= 1'b0;
                        state_ff <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    keys_ff <= 4'h0;
                    scan_step_ff <= 2'h0;
                    cnt_ff <= 32'h0000_0000;
                    state_ff <= ST_SCAN;
                end
                ST_SCAN: begin
                    // two rows by two columns only; one short drive pulse per row
                    if (!MATRIX_SCAN) begin
                        keys_ff <= {2'b00, ~key_b_sync, ~key_a_sync};
                        state_ff <= ST_SETTLE;
                        cnt_ff <= 32'h0000_0000;
                    end else if (scan_step_ff[0] == 1'b0) begin
                        // drive one row low, others released, minimal width
                        scan_row_a_ff <= 1'b0;
                        scan_row_b_ff <= 1'b0;
                        scan_row_a_oe_ff <= ~scan_step_ff[1];
                        scan_row_b_oe_ff <= scan_step_ff[1];
                        cnt_ff <= 32'h0000_0000;
                        scan_step_ff <= scan_step_ff + 2'h1;
                    end else if (cnt_ff < {24'h000000, SCAN_CYC} + 32'd4) begin
                        // wait through the three-flop sync, then release at once
                        cnt_ff <= cnt_ff + 32'h0000_0001;
                    end else begin
                        scan_row_a_oe_ff <= 1'b0;
                        scan_row_b_oe_ff <= 1'b0;
                        if (scan_step_ff[1] == 1'b0) begin
                            keys_ff[1:0] <= {~key_b_sync, ~key_a_sync};
                        end else begin
                            keys_ff[3:2] <= {~key_b_sync, ~key_a_sync};
                        end
                        cnt_ff <= 32'h0000_0000;
                        if (scan_step_ff == 2'h3) begin
                            state_ff <= ST_SETTLE;
                        end else begin
                            scan_step_ff <= scan_step_ff + 2'h1;
                        end
                    end
                end
                ST_SETTLE: begin
                    // power the transmitter; in fsk hold pa off until pll settles
                    key_code_ff <= nxt_code;
                    shift_ff <= {`RUNIN_PATTERN, `SYNC_BYTE_0, `SYNC_BYTE_1,
                        `PAYLOAD_HI, nxt_code};
                    tx_power_line_ff <= USE_POWER_LINE[0];
                    amplitude_data_line_ff <= 1'b0;
                    frequency_data_line_ff <= FSK_MODE[0];
                    if (cnt_ff >= PLL_CYCLES - 1) begin
                        cnt_ff <= 32'h0000_0000;
                        bit_ff <= 6'h00;
                        state_ff <= ST_SEND;
                    end else begin
                        cnt_ff <= cnt_ff + 32'h0000_0001;
                    end
                end
                ST_SEND: begin
                    // msb of shift register goes out for one bit time
                    if (FSK_MODE) begin
                        amplitude_data_line_ff <= 1'b1;
                        frequency_data_line_ff <= shift_ff[35];
                    end else begin
                        amplitude_data_line_ff <= shift_ff[35];
                    end
                    if (cnt_ff >= BIT_CYCLES - 1) begin
                        cnt_ff <= 32'h0000_0000;
                        shift_ff <= {shift_ff[34:0], 1'b0};
                        if (bit_ff == FRAME_BITS - 6'd1) begin
                            state_ff <= ST_END;
                        end else begin
                            bit_ff <= bit_ff + 6'h01;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 32'h0000_0001;
                    end
                end
                ST_END: begin
                    // all three low so the or-ed power-up releases
                    tx_power_line_ff <= 1'b0;
                    amplitude_data_line_ff <= 1'b0;
                    frequency_data_line_ff <= 1'b0;
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// [rtl/pin_sync.v]
// three-stage synchroniser for one asynchronous pin, change counted when stages 2 and 3 agree
`timescale 1ns/100ps
module pin_sync #(
    parameter RESET_VAL = 1'b1
) (
    input wire clk,
    input wire reset,
    input wire pin,
    output reg level_ff
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    // s1 is read only by s2
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
            level_ff <= RESET_VAL;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
            end
        end
    end
endmodule

// [tb/fob_props.sv]
// port-level checks for the keyfob wake and transmit controller
`timescale 1ns/100ps
module fob_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic pullup_disable_n,
    input wire logic pullup_enable_ff,
    input wire logic scan_row_a_oe_ff,
    input wire logic scan_row_b_oe_ff,
    input wire logic tx_power_line_ff,
    input wire logic amplitude_data_line_ff,
    input wire logic frequency_data_line_ff,
    input wire logic asleep_ff,
    input wire logic pin_wake_flag_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // one clock edge from pull-up control to pull-up state
    a_pullup_follow: assert property (1 |=> pullup_enable_ff == !$past(pullup_disable_n))
        else $error("pull-up state wrong");
    a_flag_sticky: assert property (pin_wake_flag_ff |=> pin_wake_flag_ff)
        else $error("wake flag dropped");
    a_flag_cause: assert property ($rose(pin_wake_flag_ff) |-> $past(asleep_ff))
        else $error("wake flag without sleep");
    a_wake_flags: assert property ($fell(asleep_ff) |-> ##[0:1] pin_wake_flag_ff)
        else $error("wake without flag");
    a_sleep_quiet: assert property (asleep_ff |-> !(tx_power_line_ff || amplitude_data_line_ff
        || frequency_data_line_ff)) else $error("line high in sleep");
    a_power_held: assert property ((amplitude_data_line_ff || frequency_data_line_ff)
        |-> tx_power_line_ff) else $error("power line low in use");
    a_settle_pa_off: assert property (tx_power_line_ff && !amplitude_data_line_ff
        |-> frequency_data_line_ff) else $error("settle lines wrong");
    a_scan_short: assert property (scan_row_a_oe_ff |-> ##[1:7] !scan_row_a_oe_ff)
        else $error("scan pulse long");
    a_scan_short_b: assert property (scan_row_b_oe_ff |-> ##[1:7] !scan_row_b_oe_ff)
        else $error("row b scan pulse long");
    a_one_row: assert property (!(scan_row_a_oe_ff && scan_row_b_oe_ff))
        else $error("two rows driven");
    cover property ($fell(asleep_ff));
    cover property ($rose(amplitude_data_line_ff));
    cover property ($rose(scan_row_b_oe_ff));
endmodule

// [tb/tb.sv]
// self-checking bench for the keyfob controller
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic pullup_disable_n = 1'b0;
    logic pin_wake_enable_n = 1'b1;
    logic [3:0] keys = 4'h0;
    int mismatches = 0;
    int n_checks = 0;
    wire key_input_a, key_input_b, pue, oe_a, oe_b, pwr, amp, frq, asleep, flag, powered;
    wire [7:0] code;
    wire [35:0] bits;
    wire [5:0] nbits;
    wire row_a, row_b;
    wire rest = !(oe_a | oe_b);
    // a scanned row only pulls its keys when it is driven low
    wire pull_a = (oe_a & ~row_a) | rest;
    wire pull_b = (oe_b & ~row_b) | rest;
    always #4 clk = ~clk;
    // keypad: rows rest low, so a press pulls its column unless another row scans
    assign key_input_a = ~((keys[0] & pull_a) | (keys[2] & pull_b));
    assign key_input_b = ~((keys[1] & pull_a) | (keys[3] & pull_b));
    keyfob_ctrl #(.BIT_CYCLES(4), .PLL_CYCLES(10)) dut_u (.clk, .reset, .key_input_a,
        .key_input_b, .pullup_disable_n, .pin_wake_enable_n, .pullup_enable_ff(pue),
        .scan_row_a_ff(row_a), .scan_row_b_ff(row_b), .scan_row_a_oe_ff(oe_a),
        .scan_row_b_oe_ff(oe_b),
        .tx_power_line_ff(pwr), .amplitude_data_line_ff(amp), .frequency_data_line_ff(frq),
        .asleep_ff(asleep), .pin_wake_flag_ff(flag), .key_code_ff(code));
    tx_model #(.BIT(4)) rf_u (.clk, .power_line(pwr), .amp_line(amp), .freq_line(frq),
        .powered, .bits_ff(bits), .nbits_ff(nbits));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait on sleep state; running out ends the run
    task automatic wait_sleep(input logic want, input int lim);
        for (int i = 0; i < lim && asleep !== want; i++) step(1);
        chk(asleep, want);
        if (asleep !== want) end_sim();
    endtask
    task automatic t_reset(input logic arm_n);
        reset = 1'b1;
        pin_wake_enable_n = arm_n;
        step(6);
        chk({pwr, amp, frq, asleep, flag}, 64'h0);
        reset = 1'b0;
        step(8);
        chk({asleep, flag}, 64'h2);
    endtask
    task automatic t_unarmed();
        keys = 4'h1;
        step(60);
        chk({asleep, flag, amp}, 64'h4);
        keys = 4'h0;
        step(2);
    endtask
    task automatic t_pullup();
        pullup_disable_n = 1'b1;
        step(2);
        chk(pue, 64'h0);
        pullup_disable_n = 1'b0;
        step(2);
        chk(pue, 64'h1);
    endtask
    task automatic t_frame(input logic [3:0] press, input logic [7:0] kc);
        keys = press;
        wait_sleep(1'b0, 20);
        chk(flag, 64'h1);
        wait_sleep(1'b1, 400);
        chk(bits, {28'h0, 4'ha, 8'h55, 8'haa, 8'ha5, kc});
        chk({nbits, code}, {50'h0, 6'h24, kc});
        chk({powered, pwr, amp, frq}, 64'h0);
        step(10);
        chk(asleep, 64'h1);
    endtask
    initial begin
        t_reset(1'b1);
        t_unarmed();
        t_reset(1'b0);
        t_pullup();
        for (int k = 0; k < 4; k++) begin
            t_frame(4'(1 << k), 8'(k + 1));
            t_frame(4'h0, 8'h00);
        end
        t_frame(4'hc, 8'h03);
        t_frame(4'h0, 8'h00);
        end_sim();
    end
endmodule
bind keyfob_ctrl fob_props p_u (.clk, .reset, .pullup_disable_n, .pullup_enable_ff,
    .scan_row_a_oe_ff, .scan_row_b_oe_ff, .tx_power_line_ff, .amplitude_data_line_ff,
    .frequency_data_line_ff, .asleep_ff, .pin_wake_flag_ff);

// [tb/tx_model.sv]
// transmitter stand-in: wired-or power-up and mid-bit capture of the data stream
`timescale 1ns/100ps
module tx_model #(
    parameter int BIT = 4
) (
    input wire logic clk,
    input wire logic power_line,
    input wire logic amp_line,
    input wire logic freq_line,
    output logic powered,
    output logic [35:0] bits_ff,
    output logic [5:0] nbits_ff
);
    logic amp_d_ff = 1'b0;
    int phase_ff = 0;
    // chip is up while any one line is high
    assign powered = power_line | amp_line | freq_line;
    // sample mid-bit so edge timing slips of a cycle still read right
    always @(posedge clk) begin
        amp_d_ff <= amp_line;
        phase_ff <= amp_line ? (phase_ff + 1) % BIT : 0;
        if (amp_line && !amp_d_ff) begin
            nbits_ff <= 6'h00;
        end else if (amp_line && phase_ff == BIT / 2) begin
            bits_ff <= {bits_ff[34:0], freq_line};
            nbits_ff <= nbits_ff + 6'h01;
        end
    end
endmodule
